//--- hdl/swsa_pkg.sv
// Purpose: Shared constants and types for the switch scan/arm sequencer
// Assumes: One clock domain, APB register access, 64 channels
// Notes:   Entry kinds cover single channel, channel range and stored pattern
package swsa_pkg;
	localparam int NCH   = 64;
	localparam int CHW   = 6;
	localparam int DEPTH = 16;
	localparam int IDXW  = 4;
	localparam int CNTW  = 5;
	localparam int NPAT  = 8;
	localparam int PATW  = 3;
	localparam int ACW   = 14;

	localparam logic [7:0] A_ARM_CFG   = 8'h00;
	localparam logic [7:0] A_ARM_COUNT = 8'h04;
	localparam logic [7:0] A_MODE      = 8'h08;
	localparam logic [7:0] A_STATUS    = 8'h0C;
	localparam logic [7:0] A_CLOSED_LO = 8'h10;
	localparam logic [7:0] A_CLOSED_HI = 8'h14;
	localparam logic [7:0] A_PAT_SEL   = 8'h18;
	localparam logic [7:0] A_PAT_LO    = 8'h1C;
	localparam logic [7:0] A_PAT_HI    = 8'h20;
	localparam logic [7:0] A_SL_CMD    = 8'h24;
	localparam logic [7:0] A_SL_ENTRY  = 8'h28;
	localparam logic [7:0] A_DISP_RD   = 8'h2C;

	localparam int BYP_BIT    = 3;
	localparam int SLC_IDX_LO = 4;
	localparam int ST_STATE   = 1;
	localparam int ST_DISP    = 3;
	localparam int ST_INS     = 5;
	localparam int ST_CCNT    = 6;
	localparam int ST_SCNT    = 11;
	localparam int ST_CUR     = 16;
	localparam int ST_SIDX    = 20;

	localparam logic [ACW-1:0] ARM_COUNT_RST = 14'h0001;
	localparam logic [ACW-1:0] ARM_COUNT_MAX = 14'h270F;

	typedef enum logic [1:0] {EK_SINGLE, EK_RANGE, EK_PATTERN} swsa_kind_t;
	typedef enum logic [1:0] {LOP_CHANGE, LOP_INSERT, LOP_DELETE, LOP_CLEAR} swsa_lop_t;
	typedef enum logic [2:0] {SP_IMMEDIATE, SP_MANUAL, SP_BUS, SP_EXTERNAL, SP_TBUS, SP_HOLD} swsa_spacing_t;
	typedef enum logic [1:0] {SQ_IDLE, SQ_ARM, SQ_SCAN} swsa_seq_t;
	typedef enum logic [1:0] {DS_CHAN, DS_SCAN, DS_MENU} swsa_disp_t;

	typedef struct packed {
		swsa_kind_t     kind;
		logic [CHW-1:0] first;
		logic [CHW-1:0] last;
	} swsa_entry_t;

	typedef struct packed {
		logic            valid;
		swsa_lop_t       op;
		logic [IDXW-1:0] idx;
		swsa_entry_t     entry;
	} swsa_lreq_t;

	typedef struct packed {
		logic step;
		logic bus_trig;
		logic ext_trig;
		logic tbus_trig;
	} swsa_events_t;

	typedef struct packed {
		logic enter;
		logic insert;
		logic delete_k;
		logic clear;
		logic left;
		logic right;
		logic list;
		logic exit_k;
		logic menu;
		logic close;
		logic open;
		logic open_all;
	} swsa_keys_t;
endpackage : swsa_pkg

//--- hdl/swsa_list_edit.sv
// Purpose: One editable list of channel entries with change, insert, delete, clear
// Assumes: At most one request per cycle
// Notes:   Contents are plain flops and are lost at power-down
`timescale 1ns/1ps
module swsa_list_edit (
	input  wire logic                                clk,
	input  wire logic                                rst_n,
	input  wire swsa_pkg::swsa_lreq_t                req,
	output swsa_pkg::swsa_entry_t [swsa_pkg::DEPTH-1:0] entries,
	output logic [swsa_pkg::CNTW-1:0]                count
);
	import swsa_pkg::*;

	swsa_entry_t             list_r [DEPTH];
	logic [CNTW-1:0]         count_r;
	logic [CNTW-1:0]         idx_w;
	logic                    chg_ok;
	logic                    ins_ok;
	logic                    del_ok;

	assign idx_w  = {1'b0, req.idx};
	assign chg_ok = req.valid && req.op == LOP_CHANGE && (idx_w < count_r || (idx_w == count_r && count_r < CNTW'(DEPTH)));
	assign ins_ok = req.valid && req.op == LOP_INSERT && idx_w <= count_r && count_r < CNTW'(DEPTH);
	assign del_ok = req.valid && req.op == LOP_DELETE && idx_w < count_r;

	// Each entry, whatever its kind, occupies one slot
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_ent
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					list_r[g] <= '0;
				end else if (chg_ok && req.idx == IDXW'(g)) begin
					list_r[g] <= req.entry;
				end else if (ins_ok && req.idx == IDXW'(g)) begin
					list_r[g] <= req.entry;
				end else if (ins_ok && req.idx < IDXW'(g)) begin
					list_r[g] <= list_r[(g > 0) ? g - 1 : 0];
				end else if (del_ok && req.idx <= IDXW'(g) && g < DEPTH - 1) begin
					list_r[g] <= list_r[(g < DEPTH - 1) ? g + 1 : g];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= '0;
		end else if (req.valid && req.op == LOP_CLEAR) begin
			count_r <= '0;
		end else if (ins_ok || (chg_ok && idx_w == count_r)) begin
			count_r <= count_r + 5'h01;
		end else if (del_ok) begin
			count_r <= count_r - 5'h01;
		end
	end

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			entries[i] = list_r[i];
		end
	end

	assign count   = count_r;
endmodule : swsa_list_edit

//--- hdl/swsa_top.sv
// Purpose: Channel/scan list editing, close/open control and arm-layer sequencer
// Assumes: Keys and trigger events arrive as one-cycle pulses on clk
// Notes:   Scan and channel layers sit outside; linked by arm_exit and layer_return
`timescale 1ns/1ps
module swsa_top (
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire swsa_pkg::swsa_keys_t   keys,
	input  wire swsa_pkg::swsa_entry_t  key_entry,
	input  wire swsa_pkg::swsa_events_t events,
	input  wire logic                   chan_adv,
	input  wire logic                   layer_return,
	output logic                        armed,
	output logic                        arm_exit,
	output logic                        tbus_trig_out,
	output logic                        chan_done_out,
	output logic [swsa_pkg::NCH-1:0]    closed
);
	import swsa_pkg::*;

	logic                    rs1_r;
	logic                    rst_n;
	swsa_disp_t              disp_r;
	swsa_disp_t              disp_nxt;
	swsa_seq_t               seq_r;
	logic                    ins_mode_r;
	logic [IDXW-1:0]         cursor_r;
	logic                    refresh_r;
	logic [2:0]              spacing_r;
	logic                    bypass_r;
	logic [ACW-1:0]          arm_count_r;
	logic [ACW-1:0]          passes_r;
	logic                    single_r;
	logic                    first_pass_r;
	logic [PATW-1:0]         pat_sel_r;
	logic [NCH-1:0]          pat_r [NPAT];
	swsa_entry_t             sl_entry_r;
	logic [IDXW-1:0]         disp_rd_idx_r;
	logic [NCH-1:0]          closed_r;
	logic [IDXW-1:0]         scan_idx_r;
	logic                    arm_exit_r;
	logic                    tbus_out_r;
	logic                    done_out_r;
	logic [31:0]             prdata_r;
	swsa_entry_t [DEPTH-1:0] chan_list;
	swsa_entry_t [DEPTH-1:0] scan_list;
	swsa_entry_t [DEPTH-1:0] shown_scan_r;
	logic [CNTW-1:0]         chan_cnt;
	logic [CNTW-1:0]         scan_cnt;
	logic [CNTW-1:0]         shown_cnt_r;
	logic [CNTW-1:0]         edit_cnt;
	swsa_lreq_t              front_req;
	swsa_lreq_t              chan_req;
	swsa_lreq_t              scan_req;
	swsa_lreq_t              remote_req;
	logic                    wr;
	logic                    mapped;
	logic                    edit_disp;
	logic                    open_all;
	logic                    close_ok;
	logic                    open_ok;
	logic                    arm_go;
	logic                    scan_ret;
	logic                    more_arms;
	logic                    adv_ok;
	logic [NCH-1:0]          chan_mask;
	logic [NCH-1:0]          single_mask;
	logic [NCH-1:0]          cur_mask;
	logic [NCH-1:0]          nxt_mask;
	logic [NCH-1:0]          first_mask;

	// Reset release through two flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rs1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rs1_r <= 1'b1;
			rst_n <= rs1_r;
		end
	end

	function automatic logic [NCH-1:0] entry_mask(input swsa_entry_t e, input logic [NCH-1:0] pat);
		logic [NCH-1:0] m;
		m = '0;
		for (int i = 0; i < NCH; i++) begin
			case (e.kind)
				EK_SINGLE:  m[i] = (CHW'(i) == e.first);
				EK_RANGE:   m[i] = (CHW'(i) >= e.first && CHW'(i) <= e.last) ||
				                   (CHW'(i) >= e.last && CHW'(i) <= e.first);
				EK_PATTERN: m[i] = pat[i];
				default:    m[i] = 1'b0;
			endcase
		end
		return m;
	endfunction : entry_mask

	// Masks of the channel list and of the scan walk
	always_comb begin
		chan_mask   = '0;
		single_mask = '0;
		for (int k = 0; k < DEPTH; k++) begin
			if (CNTW'(k) < chan_cnt) begin
				chan_mask = chan_mask | entry_mask(chan_list[k], pat_r[chan_list[k].first[PATW-1:0]]);
			end
		end
		for (int i = NCH - 1; i >= 0; i--) begin
			if (chan_mask[i]) begin
				single_mask    = '0;
				single_mask[i] = 1'b1;
			end
		end
	end

	assign cur_mask   = entry_mask(scan_list[scan_idx_r], pat_r[scan_list[scan_idx_r].first[PATW-1:0]]);
	assign nxt_mask   = entry_mask(scan_list[scan_idx_r + 4'h1], pat_r[scan_list[scan_idx_r + 4'h1].first[PATW-1:0]]);
	assign first_mask = entry_mask(scan_list[0], pat_r[scan_list[0].first[PATW-1:0]]);

	// Display state and cursor
	always_comb begin
		disp_nxt = disp_r;
		if (keys.exit_k) begin
			disp_nxt = DS_CHAN;
		end else if (keys.menu) begin
			disp_nxt = DS_MENU;
		end else if (keys.list && disp_r == DS_CHAN) begin
			disp_nxt = DS_SCAN;
		end else if (keys.list && disp_r == DS_SCAN) begin
			disp_nxt = DS_CHAN;
		end
	end

	assign edit_disp = (disp_r == DS_CHAN) || (disp_r == DS_SCAN);
	assign edit_cnt  = (disp_r == DS_SCAN) ? scan_cnt : chan_cnt;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			disp_r <= DS_CHAN;
		end else begin
			disp_r <= disp_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ins_mode_r <= 1'b0;
			cursor_r   <= '0;
		end else if (disp_nxt != disp_r) begin
			ins_mode_r <= 1'b0;
			cursor_r   <= '0;
		end else if (edit_disp) begin
			if (keys.insert) begin
				ins_mode_r <= ~ins_mode_r;
			end
			if (keys.clear) begin
				cursor_r <= '0;
			end else if (keys.enter && cursor_r != IDXW'(DEPTH - 1)) begin
				cursor_r <= cursor_r + 4'h1;
			end else if (keys.right && {1'b0, cursor_r} < edit_cnt && cursor_r != IDXW'(DEPTH - 1)) begin
				cursor_r <= cursor_r + 4'h1;
			end else if (keys.left && cursor_r != '0) begin
				cursor_r <= cursor_r - 4'h1;
			end
		end
	end

	// Front-panel edit request for the displayed list
	always_comb begin
		front_req = '0;
		if (edit_disp && disp_nxt == disp_r) begin
			front_req.idx   = cursor_r;
			front_req.entry = key_entry;
			if (keys.enter) begin
				front_req.valid = 1'b1;
				front_req.op    = ins_mode_r ? LOP_INSERT : LOP_CHANGE;
			end else if (keys.delete_k) begin
				front_req.valid = 1'b1;
				front_req.op    = LOP_DELETE;
			end else if (keys.clear) begin
				front_req.valid = 1'b1;
				front_req.op    = LOP_CLEAR;
			end
		end
	end

	assign wr               = psel && penable && pwrite;
	assign remote_req.valid = wr && paddr == A_SL_CMD;
	assign remote_req.op    = swsa_lop_t'(pwdata[1:0]);
	assign remote_req.idx   = pwdata[SLC_IDX_LO +: IDXW];
	assign remote_req.entry = sl_entry_r;

	always_comb begin
		chan_req = front_req;
		scan_req = front_req;
		if (disp_r != DS_CHAN) begin
			chan_req.valid = 1'b0;
		end
		if (disp_r != DS_SCAN) begin
			scan_req.valid = 1'b0;
		end
		if (remote_req.valid) begin
			scan_req = remote_req;
		end
	end

	swsa_list_edit u_chan_list (
		.clk     (clk),
		.rst_n   (rst_n),
		.req     (chan_req),
		.entries (chan_list),
		.count   (chan_cnt)
	);

	swsa_list_edit u_scan_list (
		.clk     (clk),
		.rst_n   (rst_n),
		.req     (scan_req),
		.entries (scan_list),
		.count   (scan_cnt)
	);

	// Shown scan list refreshes on display change or local edit only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			refresh_r    <= 1'b0;
			shown_scan_r <= '0;
			shown_cnt_r  <= '0;
		end else begin
			refresh_r <= (disp_nxt != disp_r) || (scan_req.valid && !remote_req.valid);
			if (refresh_r) begin
				shown_scan_r <= scan_list;
				shown_cnt_r  <= scan_cnt;
			end
		end
	end

	// Close/open and scan-walk channel state
	assign open_all = keys.open_all;
	assign close_ok = keys.close && disp_r == DS_CHAN;
	assign open_ok  = keys.open && disp_r == DS_CHAN;
	assign adv_ok   = seq_r == SQ_SCAN && chan_adv && ({1'b0, scan_idx_r} + 5'h01) < scan_cnt;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			closed_r <= '0;
		end else if (open_all) begin
			closed_r <= '0;
		end else if (arm_go && scan_cnt != '0) begin
			closed_r <= closed_r | first_mask;
		end else if (adv_ok) begin
			if (scan_list[scan_idx_r].kind == EK_PATTERN) begin
				closed_r <= closed_r | nxt_mask;
			end else begin
				closed_r <= (closed_r & ~cur_mask) | nxt_mask;
			end
		end else if (close_ok) begin
			closed_r <= closed_r | (single_r ? single_mask : chan_mask);
		end else if (open_ok) begin
			closed_r <= closed_r & ~chan_mask;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_idx_r <= '0;
		end else if (arm_go) begin
			scan_idx_r <= '0;
		end else if (adv_ok) begin
			scan_idx_r <= scan_idx_r + 4'h1;
		end
	end
	// Arm-layer sequencer
	always_comb begin
		arm_go = 1'b0;
		if (seq_r == SQ_ARM && !open_all) begin
			case (swsa_spacing_t'(spacing_r))
				SP_IMMEDIATE: arm_go = 1'b1;
				SP_MANUAL:    arm_go = events.step;
				SP_BUS:       arm_go = events.bus_trig;
				SP_EXTERNAL:  arm_go = events.ext_trig || (bypass_r && first_pass_r);
				SP_TBUS:      arm_go = events.tbus_trig || (bypass_r && first_pass_r);
				default:      arm_go = 1'b0;
			endcase
		end
	end

	assign scan_ret  = seq_r == SQ_SCAN && layer_return && !open_all;
	assign more_arms = arm_count_r == '0 || (passes_r + 14'h0001) < arm_count_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_r <= SQ_IDLE;
		end else if (open_all) begin
			seq_r <= SQ_IDLE;
		end else begin
			case (seq_r)
				SQ_IDLE: if (events.step) begin
					seq_r <= SQ_ARM;
				end
				SQ_ARM: if (arm_go) begin
					seq_r <= SQ_SCAN;
				end
				SQ_SCAN: if (scan_ret) begin
					seq_r <= more_arms ? SQ_ARM : SQ_IDLE;
				end
				default: seq_r <= SQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			passes_r     <= '0;
			first_pass_r <= 1'b1;
		end else if (seq_r == SQ_IDLE) begin
			passes_r     <= '0;
			first_pass_r <= 1'b1;
		end else begin
			if (arm_go) begin
				first_pass_r <= 1'b0;
			end
			if (scan_ret) begin
				passes_r <= passes_r + 14'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arm_exit_r <= 1'b0;
			tbus_out_r <= 1'b0;
			done_out_r <= 1'b0;
		end else begin
			arm_exit_r <= arm_go;
			tbus_out_r <= scan_ret && bypass_r && spacing_r == 3'(SP_TBUS);
			done_out_r <= scan_ret && bypass_r && spacing_r != 3'(SP_TBUS);
		end
	end

	// APB registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			spacing_r     <= 3'(SP_IMMEDIATE);
			bypass_r      <= 1'b0;
			arm_count_r   <= ARM_COUNT_RST;
			single_r      <= 1'b0;
			pat_sel_r     <= '0;
			sl_entry_r    <= '0;
			disp_rd_idx_r <= '0;
		end else if (wr) begin
			case (paddr)
				A_ARM_CFG: begin
					spacing_r <= pwdata[2:0];
					bypass_r  <= pwdata[BYP_BIT];
				end
				A_ARM_COUNT: arm_count_r <= (pwdata[ACW-1:0] > ARM_COUNT_MAX) ? ARM_COUNT_MAX : pwdata[ACW-1:0];
				A_MODE:      single_r <= pwdata[0];
				A_PAT_SEL:   pat_sel_r <= pwdata[PATW-1:0];
				A_SL_ENTRY:  sl_entry_r <= pwdata[$bits(swsa_entry_t)-1:0];
				A_DISP_RD:   disp_rd_idx_r <= pwdata[IDXW-1:0];
				default:     ;
			endcase
		end
	end

	genvar p;
	generate
		for (p = 0; p < NPAT; p++) begin : g_pat
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					pat_r[p] <= '0;
				end else if (wr && pat_sel_r == PATW'(p) && paddr == A_PAT_LO) begin
					pat_r[p][31:0] <= pwdata;
				end else if (wr && pat_sel_r == PATW'(p) && paddr == A_PAT_HI) begin
					pat_r[p][63:32] <= pwdata;
				end
			end
		end
	endgenerate

	assign mapped = paddr == A_ARM_CFG || paddr == A_ARM_COUNT || paddr == A_MODE || paddr == A_STATUS ||
	                paddr == A_CLOSED_LO || paddr == A_CLOSED_HI || paddr == A_PAT_SEL || paddr == A_PAT_LO ||
	                paddr == A_PAT_HI || paddr == A_SL_CMD || paddr == A_SL_ENTRY || paddr == A_DISP_RD;

	// Read data captured in the setup phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_r <= '0;
		end else if (psel && !penable) begin
			prdata_r <= '0;
			case (paddr)
				A_ARM_CFG:   prdata_r <= {28'h0000000, bypass_r, spacing_r};
				A_ARM_COUNT: prdata_r <= {18'h00000, arm_count_r};
				A_MODE:      prdata_r <= {31'h00000000, single_r};
				A_STATUS: begin
					prdata_r[0]                 <= seq_r != SQ_IDLE;
					prdata_r[ST_STATE +: 2]     <= seq_r;
					prdata_r[ST_DISP +: 2]      <= disp_r;
					prdata_r[ST_INS]            <= ins_mode_r;
					prdata_r[ST_CCNT +: CNTW]   <= chan_cnt;
					prdata_r[ST_SCNT +: CNTW]   <= (disp_r == DS_SCAN) ? shown_cnt_r : scan_cnt;
					prdata_r[ST_CUR +: IDXW]    <= cursor_r;
					prdata_r[ST_SIDX +: IDXW]   <= scan_idx_r;
				end
				A_CLOSED_LO: prdata_r <= closed_r[31:0];
				A_CLOSED_HI: prdata_r <= closed_r[63:32];
				A_PAT_SEL:   prdata_r <= {29'h00000000, pat_sel_r};
				A_PAT_LO:    prdata_r <= pat_r[pat_sel_r][31:0];
				A_PAT_HI:    prdata_r <= pat_r[pat_sel_r][63:32];
				A_SL_ENTRY:  prdata_r <= {18'h00000, sl_entry_r};
				A_DISP_RD:   prdata_r <= {18'h00000, (disp_r == DS_SCAN) ? shown_scan_r[disp_rd_idx_r] :
				                                     chan_list[disp_rd_idx_r]};
				default:     prdata_r <= '0;
			endcase
		end
	end

	assign prdata        = prdata_r;
	assign pready        = 1'b1;
	assign pslverr       = psel && penable && !mapped;
	assign armed         = seq_r != SQ_IDLE;
	assign arm_exit      = arm_exit_r;
	assign tbus_trig_out = tbus_out_r;
	assign chan_done_out = done_out_r;
	assign closed        = closed_r;
endmodule : swsa_top

//--- verification/swsa_props.sv
// Purpose: Port checks for swsa_top
// Assumes: One clock, arst_n low resets
// Notes:   Bound to every swsa_top
`timescale 1ns/1ps
module swsa_props (
	input wire logic                   clk,
	input wire logic                   arst_n,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire swsa_pkg::swsa_keys_t   keys,
	input wire swsa_pkg::swsa_events_t events,
	input wire logic                   layer_return,
	input wire logic                   armed,
	input wire logic                   arm_exit,
	input wire logic                   tbus_trig_out,
	input wire logic                   chan_done_out,
	input wire logic [swsa_pkg::NCH-1:0] closed
);
	import swsa_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	pready_hi_a: assert property (pready) else $error("pready low");
	err_phase_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
	abort_idle_a: assert property (keys.open_all |=> !armed) else $error("open all left armed");
	abort_open_a: assert property (keys.open_all |=> closed == '0) else $error("open all left closed");
	step_arm_a: assert property (!armed && events.step && !keys.open_all |=> armed) else $error("step ignored");
	exit_scan_a: assert property (arm_exit |-> armed && $past(armed)) else $error("exit while idle");
	trig_ret_a: assert property (tbus_trig_out || chan_done_out |-> $past(layer_return)
		&& !(tbus_trig_out && chan_done_out)) else $error("stray trigger");
	idle_hold_a: assert property (!armed && !(keys.close || keys.open || keys.open_all)
		|=> $stable(closed)) else $error("closed moved in idle");
	cover property (arm_exit);
	cover property (chan_done_out);
	cover property (tbus_trig_out);
endmodule : swsa_props
bind swsa_top swsa_props props_u (.clk, .arst_n, .psel, .penable, .pready, .pslverr, .keys, .events,
	.layer_return, .armed, .arm_exit, .tbus_trig_out, .chan_done_out, .closed);

//--- verification/swsa_src.sv
// Purpose: Trigger source model for the event inputs
// Assumes: Bench asks by go with a mask
// Notes:   Waits dly cycles, then one pulse
`timescale 1ns/1ps
module swsa_src (
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	input  wire logic                   go,
	input  wire swsa_pkg::swsa_events_t sel,
	input  wire logic [3:0]             dly,
	output swsa_pkg::swsa_events_t      events
);
	import swsa_pkg::*;
	swsa_events_t pend_r;
	logic [3:0]   cnt_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			events <= '0;
			pend_r <= '0;
			cnt_r <= '0;
		end else begin
			events <= '0;
			if (go) begin
				pend_r <= sel;
				cnt_r <= dly;
			end else if (cnt_r != 0) begin
				cnt_r <= cnt_r - 1;
			end else begin
				events <= pend_r;
				pend_r <= '0;
			end
		end
	end
endmodule : swsa_src

//--- verification/test_switch_scan_arm_sequencer.sv
// Purpose: Self-checking bench for swsa_top
// Assumes: APB master, key pulses, source model
// Notes:   Random values from xorshift
`timescale 1ns/1ps
module test_switch_scan_arm_sequencer;
	import swsa_pkg::*;
	logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, chan_adv = 0, layer_return = 0, go = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q, rs = 32'h8047;
	logic [3:0] dly = 0;
	logic pready, pslverr, e, armed, arm_exit, tbo, cdo;
	logic [63:0] closed;
	swsa_keys_t keys = '0;
	swsa_entry_t key_entry = '0;
	swsa_events_t sel = '0, events;
	int err_total = 0, compares = 0, cyc = 0, nt = 0, nc = 0, na = 0;
	swsa_top dut_u (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .keys,
		.key_entry, .events, .chan_adv, .layer_return, .armed, .arm_exit, .tbus_trig_out(tbo),
		.chan_done_out(cdo), .closed);
	swsa_src src_u (.clk, .arst_n, .go, .sel, .dly, .events);
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		nt += int'(tbo);
		nc += int'(cdo);
		na += int'(arm_exit);
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			close_out();
		end
	end
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xs
	function automatic logic [63:0] mk(swsa_entry_t x);
		logic [63:0] m;
		m = '0;
		for (int i = 0; i < 64; i++)
			if ((i >= x.first && i <= x.last) || (i >= x.last && i <= x.first)) m[i] = 1'b1;
		return m;
	endfunction : mk
	task automatic chk(input logic [63:0] g, input logic [63:0] x);
		compares++;
		if (g !== x) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(0, a, 0);
		chk(64'(q), 64'(x));
	endtask : rd
	task automatic key(input int n, input swsa_entry_t x);
		@(posedge clk);
		keys <= swsa_keys_t'(12'h1 << n);
		key_entry <= x;
		@(posedge clk);
		keys <= '0;
		@(posedge clk);
	endtask : key
	task automatic ev(input logic [3:0] m);
		@(posedge clk);
		go <= 1;
		sel <= m;
		dly <= 4'(xs());
		@(posedge clk);
		go <= 0;
		repeat (20) @(posedge clk);
	endtask : ev
	task automatic pl(input logic r);
		@(posedge clk);
		if (r) layer_return <= 1;
		else chan_adv <= 1;
		@(posedge clk);
		layer_return <= 0;
		chan_adv <= 0;
		@(posedge clk);
	endtask : pl
	task automatic close_out();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out
	initial begin
		swsa_entry_t a, b, c;
		int n0;
		repeat (3) @(posedge clk);
		arst_n <= 1;
		repeat (3) @(posedge clk);
		rd(A_STATUS, 0);
		rd(A_ARM_CFG, 0);
		rd(A_ARM_COUNT, 1);
		rd(A_CLOSED_LO, 0);
		apb(1, A_ARM_COUNT, 12000);
		rd(A_ARM_COUNT, 9999);
		apb(0, 8'h3C, 0);
		chk(64'(e), 1);
		$display("registers done");
		a = '{EK_SINGLE, 6'(xs()), 6'h0};
		a.last = a.first;
		b = '{EK_RANGE, 6'(xs()), 6'(xs())};
		c = '{EK_PATTERN, 6'(xs() & 7), 6'h0};
		key(11, a);
		key(11, b);
		key(2, a);
		chk(closed, mk(a) | mk(b));
		key(7, a);
		key(7, a);
		key(9, a);
		key(1, a);
		chk(closed, mk(a) & ~mk(b));
		key(10, a);
		key(11, c);
		apb(0, A_STATUS, 0);
		chk(64'(q[10:5]), 6'h5);
		apb(1, A_DISP_RD, 0);
		rd(A_DISP_RD, 32'(c));
		apb(1, A_DISP_RD, 1);
		rd(A_DISP_RD, 32'(b));
		key(10, a);
		apb(0, A_STATUS, 0);
		chk(64'(q[5]), 0);
		key(8, a);
		apb(0, A_STATUS, 0);
		chk(64'(q[10:6]), 0);
		key(0, a);
		chk(closed, 0);
		apb(1, A_MODE, 1);
		key(11, b);
		key(2, a);
		chk(closed, 64'h1 << (b.first < b.last ? b.first : b.last));
		key(3, a);
		key(2, a);
		chk(closed, 64'h1 << (b.first < b.last ? b.first : b.last));
		key(0, a);
		chk(closed, 0);
		key(4, a);
		apb(1, A_MODE, 0);
		n0 = xs();
		apb(1, A_PAT_SEL, 32'(c.first));
		apb(1, A_PAT_LO, n0);
		apb(1, A_PAT_HI, ~n0);
		key(11, c);
		key(2, a);
		chk(closed, {32'(~n0), 32'(n0)});
		key(0, a);
		$display("edit and close done");
		apb(1, A_SL_ENTRY, 32'(a));
		apb(1, A_SL_CMD, 0);
		apb(1, A_SL_ENTRY, 32'(b));
		apb(1, A_SL_CMD, 32'h10);
		apb(1, A_ARM_COUNT, 1);
		ev(4'h8);
		chk(closed, mk(a));
		pl(0);
		chk(closed, mk(b));
		pl(1);
		chk({63'h0, armed}, 0);
		chk(closed, mk(b));
		key(5, a);
		apb(1, A_SL_CMD, 32'h20);
		apb(0, A_STATUS, 0);
		chk(64'(q[15:11]), 2);
		key(5, a);
		key(5, a);
		apb(0, A_STATUS, 0);
		chk(64'(q[15:11]), 3);
		key(4, a);
		for (int s = 0; s < 6; s++) begin
			apb(1, A_ARM_CFG, s);
			n0 = na;
			ev(4'h8);
			if (s != 0) ev(s == 5 ? 4'hF : 4'(16 >> s));
			chk(64'(na - n0), 64'(s != 5));
			if (s != 5) pl(1);
			else key(0, a);
		end
		chk(64'(nt + nc), 0);
		for (int s = 3; s < 5; s++) begin
			apb(1, A_ARM_CFG, 8 + s);
			apb(1, A_ARM_COUNT, 2);
			n0 = na;
			ev(4'h8);
			pl(1);
			ev(4'h0);
			chk(64'(na - n0), 1);
			ev(4'(16 >> s));
			pl(1);
			chk({63'h0, armed}, 0);
			ev(4'h8);
			chk(64'(na - n0), 3);
			key(0, a);
			chk({63'h0, armed}, 0);
		end
		chk(64'(nc), 2);
		chk(64'(nt), 2);
		$display("sequencer done");
		close_out();
	end
endmodule : test_switch_scan_arm_sequencer
